// ===== useq_pkg.sv
/*
  Package for the microsequencer address and bus decode block: microword
  field positions, sequencer control codes, bus select codes and the
  AXI4-Lite register offsets.
  Assumes a 40-bit microword and a 16-bit processor bus.
*/
package useq_pkg;

  // ---------------------------------------------------------------
  // Microword layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 40;
  localparam int ADDR_W = 12;
  localparam int SRC_LO = 0;
  localparam int DST_LO = 4;
  localparam int SEL_W = 4;
  localparam int CONST_BIT = 12;
  localparam int CTL_LO = 16;
  localparam int CTL_W = 3;
  localparam int TARGET_LO = 28;
  localparam int CONST_LO = 0;
  localparam int BYTE_W = 8;
  localparam int BUS_W = 16;
  localparam int NSEL = 16;

  // ---------------------------------------------------------------
  // Sequencer control codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CTL_RETURN = 3'h1;
  localparam logic [2:0] CTL_DISPATCH = 3'h3;
  localparam logic [2:0] CTL_CALL = 3'h5;
  localparam logic [2:0] CTL_BRANCH = 3'h7;
  localparam logic [2:0] CTL_CONTINUE = 3'h0;

  // ---------------------------------------------------------------
  // Bus source and destination codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SRC_OPCODE = 4'h1;
  localparam logic [3:0] SRC_OPERAND_POS = 4'h2;
  localparam logic [3:0] SRC_OPERAND_ALT = 4'h3;
  localparam logic [3:0] SRC_OPERAND_NEG = 4'h4;
  localparam logic [3:0] SRC_MASK = 4'h5;
  localparam logic [3:0] DST_ALU = 4'h1;
  localparam logic [3:0] DST_MASK = 4'h5;
  localparam logic [11:0] IRQ_VECTOR_BASE = 12'h008;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_MAP_WRITE = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_PENDING = 8'h0C;
  localparam logic [7:0] REG_STACK = 8'h10;
  localparam int MAP_IDX_LO = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic [NSEL-1:0] src_sel_n;
    logic [NSEL-1:0] dst_sel_n;
    logic [BUS_W-1:0] bus_out;
    logic bus_out_en;
  } bus_ctl_t;

endpackage

// ===== useq_decode.sv
/*
  Microsequencer next-address selection and bus-transfer decode.
  Assumes the microword register is loaded by the surrounding control
  store logic on each enabled clk_sys edge, and that cpu_strobe is
  synchronous with clk_sys and marks the microcycle in which bus
  destinations load.
*/
`timescale 1ns/1ps

// How it works
// RQ1 - Every microcycle, current address plus one is held as the continue target.
// RQ2 - Sequencer control code comes from microword bits 16 to 18 via a mux.
// RQ3 - Branch drives microword bits 28 to 39 in; code 111 passes them through.
// RQ4 - Failed condition substitutes the continue code, giving the incremented address.
// RQ5 - Call branches and pushes next sequential address; plain jump does not push.
// RQ6 - Dispatch indexes a 256 by 12 map with the bus opcode byte.
// RQ7 - Map output reaches the parallel input on a dispatch with no interrupt pending; map gate enable goes low one edge later.
// RQ8 - Interrupt vector replaces dispatch only on opcode-source microinstructions.
// RQ9 - Requests are latched in a holding register and gated by clear mask bits.
// RQ10 - Encoder yields highest unmasked index; pending deasserts the map gate enable.
// RQ11 - Taken interrupt sends encoder index plus 8 as the next address.
// RQ12 - Code 001 returns to the address on top of the internal stack.
// RQ13 - Bits 0 to 3 select the bus source, bits 4 to 7 the destination.
// RQ14 - Fields decode to 32 active-low one-hot select lines.
// RQ15 - Source drives for the whole cycle; destination loads on select and strobe.
// RQ16 - Decoders are enabled only while microword bit 12 is low.
// RQ17 - Constant format forces the ALU destination select active.
// RQ18 - Destinations ignore select changes when no CPU strobe is issued.
// RQ19 - Constant puts microword bits 0 to 7 on the bus low byte, zero above.
// RQ20 - Unsigned opcode and operand sources zero the upper byte; negative sets ones.
// RQ21 - Mask register loads from bus on its select with strobe and drives on read.
// RQ22 - Reset clears the mask register and the interrupt holding register.
module useq_decode #(
  parameter int NIRQ = 8,
  parameter int STACK_DEPTH = 17
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [useq_pkg::WORD_W-1:0] microword_register,
  input wire logic condition_ok,
  input wire logic cpu_strobe,
  input wire logic [useq_pkg::BUS_W-1:0] bus_in,
  input wire logic [useq_pkg::BYTE_W-1:0] fetch_unit_byte,
  input wire logic [NIRQ-1:0] irq_in,
  input wire useq_pkg::axil_req_t axi_req,
  output useq_pkg::axil_rsp_t axi_rsp,
  output logic [useq_pkg::ADDR_W-1:0] micro_addr,
  output useq_pkg::bus_ctl_t bus_ctl,
  output logic map_gate_en_n,
  output logic dst_mask_strobe
);
  import useq_pkg::*;

  if (NIRQ < 1 || NIRQ > BYTE_W) begin
    $error("NIRQ must be 1 to 8");
  end
  if (STACK_DEPTH < 1 || STACK_DEPTH > 64) begin
    $error("STACK_DEPTH out of range");
  end

  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam int IDX_W = (NIRQ > 1) ? $clog2(NIRQ) : 1;

  // ---------------------------------------------------------------
  // Synchronised interrupt requests and holding register
  // ---------------------------------------------------------------
  logic [NIRQ-1:0] irq_meta;
  logic [NIRQ-1:0] irq_sync;
  logic [NIRQ-1:0] irq_hold;
  logic [BYTE_W-1:0] irq_mask;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_meta <= '0;
      irq_sync <= '0;
    end else if (clk_en) begin
      irq_meta <= irq_in;
      irq_sync <= irq_meta;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_hold <= '0; // RQ22
    end else if (clk_en) begin
      irq_hold <= irq_sync; // RQ9
    end
  end

  logic [NIRQ-1:0] irq_live;
  logic irq_pending;
  logic [IDX_W-1:0] irq_index;

  always_comb begin
    irq_live = irq_hold & ~irq_mask[NIRQ-1:0]; // RQ9
    irq_pending = |irq_live;
    irq_index = '0;
    for (int i = 0; i < NIRQ; i++) begin
      if (irq_live[i]) begin
        irq_index = IDX_W'(i); // RQ10
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus select decode
  // ---------------------------------------------------------------
  logic constant_sel_n;
  logic [SEL_W-1:0] src_code;
  logic [SEL_W-1:0] dst_code;
  logic [NSEL-1:0] next_src_sel_n;
  logic [NSEL-1:0] next_dst_sel_n;

  always_comb begin
    constant_sel_n = ~microword_register[CONST_BIT];
    src_code = microword_register[SRC_LO +: SEL_W]; // RQ13
    dst_code = microword_register[DST_LO +: SEL_W]; // RQ13
    next_src_sel_n = '1;
    next_dst_sel_n = '1;
    if (constant_sel_n) begin // RQ16
      next_src_sel_n[src_code] = 1'b0; // RQ14
      next_dst_sel_n[dst_code] = 1'b0; // RQ14
    end else begin
      next_dst_sel_n[DST_ALU] = 1'b0; // RQ17
    end
  end

  logic src_opcode_sel_n;
  logic src_operand_pos_sel_n;
  logic src_operand_alt_sel_n;
  logic src_operand_neg_sel_n;
  logic src_mask_sel_n;
  logic dst_mask_sel_n;
  logic dst_alu_sel_n;

  always_comb begin
    src_opcode_sel_n = next_src_sel_n[SRC_OPCODE];
    src_operand_pos_sel_n = next_src_sel_n[SRC_OPERAND_POS];
    src_operand_alt_sel_n = next_src_sel_n[SRC_OPERAND_ALT];
    src_operand_neg_sel_n = next_src_sel_n[SRC_OPERAND_NEG];
    src_mask_sel_n = next_src_sel_n[SRC_MASK];
    dst_mask_sel_n = next_dst_sel_n[DST_MASK];
    dst_alu_sel_n = next_dst_sel_n[DST_ALU];
  end

  // ---------------------------------------------------------------
  // Bus data driven by this block
  // ---------------------------------------------------------------
  logic [BUS_W-1:0] next_bus_out;
  logic next_bus_en;

  always_comb begin
    next_bus_out = '0;
    next_bus_en = 1'b0;
    if (!constant_sel_n) begin
      next_bus_out = {{BYTE_W{1'b0}}, microword_register[CONST_LO +: BYTE_W]}; // RQ19
      next_bus_en = 1'b1;
    end else if (!src_opcode_sel_n || !src_operand_pos_sel_n || !src_operand_alt_sel_n) begin
      next_bus_out = {{BYTE_W{1'b0}}, fetch_unit_byte}; // RQ20
      next_bus_en = 1'b1;
    end else if (!src_operand_neg_sel_n) begin
      next_bus_out = {{BYTE_W{1'b1}}, fetch_unit_byte}; // RQ20
      next_bus_en = 1'b1;
    end else if (!src_mask_sel_n) begin
      next_bus_out = {{BYTE_W{1'b0}}, irq_mask}; // RQ21
      next_bus_en = 1'b1;
    end
  end

  // Selects are registered for the whole microcycle so sources drive steadily.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_ctl.src_sel_n <= '1;
      bus_ctl.dst_sel_n <= '1;
      bus_ctl.bus_out <= '0;
      bus_ctl.bus_out_en <= 1'b0;
    end else if (clk_en) begin
      bus_ctl.src_sel_n <= next_src_sel_n; // RQ15
      bus_ctl.dst_sel_n <= next_dst_sel_n;
      bus_ctl.bus_out <= next_bus_out;
      bus_ctl.bus_out_en <= next_bus_en;
    end
  end

  // A destination loads only on select and strobe together, so glitchy
  // selects without a strobe have no effect.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dst_mask_strobe <= 1'b0;
    end else if (clk_en) begin
      dst_mask_strobe <= ~dst_mask_sel_n & cpu_strobe; // RQ18
    end
  end

  // ---------------------------------------------------------------
  // Opcode map memory, written by software
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] op_map [0:(1 << BYTE_W) - 1];
  logic map_we;
  logic [BYTE_W-1:0] map_waddr;
  logic [ADDR_W-1:0] map_wdata;

  always_ff @(posedge clk_sys) begin
    if (map_we) begin
      op_map[map_waddr] <= map_wdata;
    end
  end

  logic [ADDR_W-1:0] map_value;
  logic dispatch;
  logic take_irq;

  always_comb begin
    map_value = op_map[bus_in[BYTE_W-1:0]]; // RQ6
    dispatch = !src_opcode_sel_n;
    take_irq = dispatch && irq_pending; // RQ8
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      map_gate_en_n <= 1'b1;
    end else if (clk_en) begin
      map_gate_en_n <= !(dispatch && !irq_pending); // RQ10
    end
  end

  // ---------------------------------------------------------------
  // Sequencer: control mux, stack and next address
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] stack_mem [0:STACK_DEPTH-1];
  logic [SP_W-1:0] sp;
  logic [ADDR_W-1:0] incremented;
  logic [CTL_W-1:0] ctl_field;
  logic [CTL_W-1:0] ctl;
  logic [ADDR_W-1:0] parallel_in;
  logic [ADDR_W-1:0] next_addr;
  logic push;
  logic pop;

  always_comb begin
    incremented = micro_addr + ADDR_W'(1); // RQ1
    ctl_field = microword_register[CTL_LO +: CTL_W]; // RQ2
    ctl = ctl_field;
    if ((ctl_field == CTL_BRANCH || ctl_field == CTL_CALL) && !condition_ok) begin
      ctl = CTL_CONTINUE; // RQ4
    end
    parallel_in = microword_register[TARGET_LO +: ADDR_W]; // RQ3
    if (take_irq) begin
      parallel_in = IRQ_VECTOR_BASE + ADDR_W'(irq_index); // RQ11
    end else if (dispatch) begin
      parallel_in = map_value; // RQ7
    end
    push = 1'b0;
    pop = 1'b0;
    if (dispatch) begin
      next_addr = parallel_in;
    end else begin
      unique case (ctl)
        CTL_BRANCH: next_addr = parallel_in; // RQ3
        CTL_CALL: begin
          next_addr = parallel_in;
          push = 1'b1; // RQ5
        end
        CTL_RETURN: begin
          next_addr = (sp != '0) ? stack_mem[sp - SP_W'(1)] : incremented; // RQ12
          pop = (sp != '0);
        end
        default: next_addr = incremented; // RQ1
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      micro_addr <= '0;
    end else if (clk_en) begin
      micro_addr <= next_addr;
    end
  end

  // Overflow drops the push rather than wrapping over the oldest entry.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sp <= '0;
    end else if (clk_en) begin
      if (push && sp != SP_W'(STACK_DEPTH)) begin
        stack_mem[sp] <= incremented; // RQ5
        sp <= sp + SP_W'(1);
      end else if (pop) begin
        sp <= sp - SP_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic do_write;
  logic bus_mask_load;

  always_comb begin
    do_write = aw_held && w_held && !axi_rsp.bvalid;
    map_we = clk_en && do_write && aw_addr == REG_MAP_WRITE;
    map_waddr = w_data[MAP_IDX_LO +: BYTE_W];
    map_wdata = w_data[ADDR_W-1:0];
    bus_mask_load = ~dst_mask_sel_n & cpu_strobe;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      axi_rsp.awready <= 1'b0;
      axi_rsp.wready <= 1'b0;
      axi_rsp.bvalid <= 1'b0;
      axi_rsp.bresp <= RESP_OKAY;
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid <= 1'b0;
      axi_rsp.rdata <= '0;
      axi_rsp.rresp <= RESP_OKAY;
    end else if (clk_en) begin
      axi_rsp.awready <= !aw_held && !axi_rsp.awready;
      axi_rsp.wready <= !w_held && !axi_rsp.wready;
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_held <= 1'b1;
        aw_addr <= axi_req.awaddr;
        axi_rsp.awready <= 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_held <= 1'b1;
        w_data <= axi_req.wdata;
        axi_rsp.wready <= 1'b0;
      end
      if (do_write) begin
        axi_rsp.bvalid <= 1'b1;
        axi_rsp.bresp <= (aw_addr == REG_MAP_WRITE || aw_addr == REG_MASK) ? RESP_OKAY
                                                                           : RESP_SLVERR;
      end
      if (axi_rsp.bvalid && axi_req.bready) begin
        axi_rsp.bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      axi_rsp.arready <= !axi_rsp.rvalid && !axi_rsp.arready;
      if (axi_req.arvalid && axi_rsp.arready) begin
        axi_rsp.arready <= 1'b0;
        axi_rsp.rvalid <= 1'b1;
        axi_rsp.rresp <= RESP_OKAY;
        unique case (axi_req.araddr)
          REG_ADDR: axi_rsp.rdata <= 32'(micro_addr);
          REG_MASK: axi_rsp.rdata <= 32'(irq_mask);
          REG_PENDING: axi_rsp.rdata <= 32'(irq_live);
          REG_STACK: axi_rsp.rdata <= 32'(sp);
          default: begin
            axi_rsp.rdata <= '0;
            axi_rsp.rresp <= RESP_SLVERR;
          end
        endcase
      end else if (axi_rsp.rvalid && axi_req.rready) begin
        axi_rsp.rvalid <= 1'b0;
      end
    end
  end

  // The bus load wins over a software write in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_mask <= '0; // RQ22
    end else if (clk_en) begin
      if (bus_mask_load) begin
        irq_mask <= bus_in[BYTE_W-1:0]; // RQ21
      end else if (do_write && aw_addr == REG_MASK && w_data[BYTE_W-1:0] != irq_mask) begin
        irq_mask <= w_data[BYTE_W-1:0];
      end
    end
  end

endmodule

// ===== useq_decode_properties.sv
/*
  Checker for useq_decode, bound to its ports.
  Assumes one clock, clk_sys, and a synchronous reset, rst.
*/
`timescale 1ns/1ps
module useq_decode_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [useq_pkg::WORD_W-1:0] microword_register,
  input wire logic condition_ok,
  input wire logic cpu_strobe,
  input wire logic [useq_pkg::BYTE_W-1:0] fetch_unit_byte,
  input wire logic [useq_pkg::ADDR_W-1:0] micro_addr,
  input wire useq_pkg::bus_ctl_t bus_ctl,
  input wire logic map_gate_en_n,
  input wire logic dst_mask_strobe
);
  import useq_pkg::*;
  logic [3:0] src;
  logic [2:0] ctl;
  logic cst;
  logic disp;
  logic live;
  assign src = microword_register[SRC_LO+:SEL_W];
  assign ctl = microword_register[CTL_LO+:CTL_W];
  assign cst = microword_register[CONST_BIT];
  assign disp = !cst && src == SRC_OPCODE;
  // Registered outputs lag one edge, so nothing is judged on the edge that leaves reset.
  always_ff @(posedge clk_sys) begin
    live <= !rst && clk_en;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_src_decode:
  assert property (live && !$past(cst) |-> bus_ctl.src_sel_n == ~(16'h0001 << $past(src)))
    else $error("source select does not match the microword");
  a_const_dst:
  assert property (live && $past(cst) |->
    bus_ctl.dst_sel_n == ~(16'h0001 << DST_ALU) && bus_ctl.src_sel_n == 16'hFFFF)
    else $error("constant format selects are wrong");
  a_const_bus:
  assert property (live && $past(cst) |->
    bus_ctl.bus_out == {8'h00, $past(microword_register[7:0])} && bus_ctl.bus_out_en)
    else $error("constant not on the bus");
  a_neg_upper:
  assert property (live && !$past(cst) && $past(src) == SRC_OPERAND_NEG |->
    bus_ctl.bus_out == {8'hFF, $past(fetch_unit_byte)})
    else $error("negative operand upper byte wrong");
  a_pos_upper:
  assert property (live && !$past(cst) && $past(src) >= SRC_OPCODE &&
    $past(src) <= SRC_OPERAND_ALT |-> bus_ctl.bus_out == {8'h00, $past(fetch_unit_byte)})
    else $error("unsigned operand upper byte wrong");
  a_branch_taken:
  assert property (live && $past(ctl) == CTL_BRANCH && $past(condition_ok) && !$past(disp)
    |-> micro_addr == $past(microword_register[TARGET_LO+:ADDR_W]))
    else $error("branch target not taken");
  a_branch_fail:
  assert property (live && $past(ctl) == CTL_BRANCH && !$past(condition_ok) && !$past(disp)
    |-> micro_addr == $past(micro_addr) + 12'h001)
    else $error("failed branch did not continue");
  a_continue_inc:
  assert property (live && $past(ctl) == CTL_CONTINUE && !$past(disp)
    |-> micro_addr == $past(micro_addr) + 12'h001)
    else $error("continue did not increment");
  a_gate_dispatch:
  assert property (!map_gate_en_n |-> $past(disp))
    else $error("map gate enabled without dispatch");
  a_strobe_cause:
  assert property (dst_mask_strobe |-> $past(cpu_strobe))
    else $error("mask strobe without cpu strobe");
  c_dispatch: cover property (live && $past(disp) && !map_gate_en_n);
  c_const: cover property (live && $past(cst) && $past(cpu_strobe));
  c_mask_load: cover property (dst_mask_strobe);
endmodule
bind useq_decode useq_decode_properties i_useq_decode_properties (
  .clk_sys(clk_sys),
  .rst(rst),
  .clk_en(clk_en),
  .microword_register(microword_register),
  .condition_ok(condition_ok),
  .cpu_strobe(cpu_strobe),
  .fetch_unit_byte(fetch_unit_byte),
  .micro_addr(micro_addr),
  .bus_ctl(bus_ctl),
  .map_gate_en_n(map_gate_en_n),
  .dst_mask_strobe(dst_mask_strobe)
);

// ===== useq_alu_model.sv
/*
  ALU bus destination model beside useq_decode.
  Assumes bus_ctl lags the microword and its strobe by one cycle.
*/
`timescale 1ns/1ps
module useq_alu_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cpu_strobe,
  input wire useq_pkg::bus_ctl_t bus_ctl,
  output logic [useq_pkg::BUS_W-1:0] alu_reg
);
  import useq_pkg::*;
  logic strobe_d;
  always_ff @(posedge clk_sys) begin
    strobe_d <= cpu_strobe;
  end
  // A select that moves without the strobe must leave the register alone.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alu_reg <= '0;
    end else if (strobe_d && !bus_ctl.dst_sel_n[DST_ALU]) begin
      alu_reg <= bus_ctl.bus_out;
    end
  end
endmodule

// ===== microsequencer_address_and_bus_decode_tb_top.sv
/*
  Self-checking bench for useq_decode with an ALU destination model.
  Assumes selects and addresses settle one edge after the microword.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module microsequencer_address_and_bus_decode_tb_top;
  import useq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [WORD_W-1:0] mword = '0;
  logic cond = 1'b0;
  logic strobe = 1'b0;
  logic [BUS_W-1:0] bus_in = '0;
  logic [BYTE_W-1:0] fbyte = 8'hA7;
  logic [7:0] irq = '0;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic [ADDR_W-1:0] micro_addr;
  bus_ctl_t bus_ctl;
  logic gate_n;
  logic mask_strobe;
  logic [BUS_W-1:0] alu_reg;
  logic [31:0] rd;
  logic [1:0] resp;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  useq_decode i_useq_decode (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(1'b1),
    .microword_register(mword),
    .condition_ok(cond),
    .cpu_strobe(strobe),
    .bus_in(bus_in),
    .fetch_unit_byte(fbyte),
    .irq_in(irq),
    .axi_req(req),
    .axi_rsp(rsp),
    .micro_addr(micro_addr),
    .bus_ctl(bus_ctl),
    .map_gate_en_n(gate_n),
    .dst_mask_strobe(mask_strobe)
  );
  useq_alu_model i_useq_alu_model (
    .clk_sys(clk_sys),
    .rst(rst),
    .cpu_strobe(strobe),
    .bus_ctl(bus_ctl),
    .alu_reg(alu_reg)
  );
  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  function automatic logic [WORD_W-1:0] mw(input logic [2:0] c, input logic [3:0] s,
    input logic [3:0] d, input logic k, input logic [ADDR_W-1:0] t);
    logic [WORD_W-1:0] w;
    w = '0;
    w[SRC_LO+:SEL_W] = s;
    w[DST_LO+:SEL_W] = d;
    w[CONST_BIT] = k;
    w[CTL_LO+:CTL_W] = c;
    w[TARGET_LO+:ADDR_W] = t;
    return w;
  endfunction
  // One microword for exactly one edge, then plain continue words again.
  task automatic run(input logic [WORD_W-1:0] w, input logic c, input logic s,
    input logic [BUS_W-1:0] b);
    @(posedge clk_sys);
    mword <= w;
    cond <= c;
    strobe <= s;
    bus_in <= b;
    @(posedge clk_sys);
    mword <= '0;
    strobe <= 1'b0;
    #1;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys);
    req <= '{awaddr: a, awvalid: 1'b1, wdata: d, wstrb: 4'hF, wvalid: 1'b1, bready: 1'b1,
      default: 0};
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (rsp.awready === 1'b1) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready === 1'b1) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    while (rsp.bvalid !== 1'b1) @(posedge clk_sys);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys);
    req <= '{araddr: a, arvalid: 1'b1, rready: 1'b1, default: 0};
    do @(posedge clk_sys); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_sys); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    irq <= '0;
    repeat (16) @(posedge clk_sys);
    #1;
    `CHK("reset address", 12'h000, micro_addr)
    `CHK("reset selects", 16'hFFFF, bus_ctl.src_sel_n)
    `CHK("reset gate", 1'b1, gate_n)
    @(posedge clk_sys);
    rst <= 1'b0;
    axr(REG_MASK);
    `CHK("reset mask", 32'h00000000, rd)
    axr(REG_PENDING);
    `CHK("reset pending", 32'h00000000, rd)
    axr(8'h40);
    `CHK("unmapped read", 2'h2, resp)
    axw(REG_ADDR, 32'h00000000);
    `CHK("read-only write", RESP_SLVERR, resp)
  endtask
  task automatic t_sequence;
    run(mw(CTL_BRANCH, 4'h0, 4'h0, 1'b0, 12'h123), 1'b1, 1'b0, 16'h0000);
    `CHK("branch", 12'h123, micro_addr)
    run(mw(CTL_BRANCH, 4'h0, 4'h0, 1'b0, 12'h456), 1'b0, 1'b0, 16'h0000);
    `CHK("failed branch", 12'h125, micro_addr)
    run(mw(CTL_CONTINUE, 4'h0, 4'h0, 1'b0, 12'h777), 1'b1, 1'b0, 16'h0000);
    `CHK("continue", 12'h127, micro_addr)
    run(mw(CTL_CALL, 4'h0, 4'h0, 1'b0, 12'h200), 1'b1, 1'b0, 16'h0000);
    `CHK("call", 12'h200, micro_addr)
    axr(REG_STACK);
    `CHK("depth after call", 32'h00000001, rd)
    run(mw(CTL_RETURN, 4'h0, 4'h0, 1'b0, 12'h000), 1'b1, 1'b0, 16'h0000);
    `CHK("return", 12'h129, micro_addr)
    run(mw(CTL_BRANCH, 4'h0, 4'h0, 1'b0, 12'h300), 1'b1, 1'b0, 16'h0000);
    axr(REG_STACK);
    `CHK("depth after jump", 32'h00000000, rd)
  endtask
  task automatic t_dispatch;
    axw(REG_MAP_WRITE, 32'h003C05A5);
    run(mw(CTL_CONTINUE, SRC_OPCODE, 4'h0, 1'b0, 12'h000), 1'b0, 1'b0, 16'h003C);
    `CHK("dispatch", 12'h5A5, micro_addr)
    `CHK("map gate", 1'b0, gate_n)
    run(mw(CTL_BRANCH, SRC_OPCODE, 4'h0, 1'b1, 12'h0F0), 1'b1, 1'b0, 16'h003C);
    `CHK("constant not dispatch", 12'h0F0, micro_addr)
  endtask
  task automatic t_irq;
    axw(REG_MASK, 32'h00000020);
    irq <= 8'h28;
    repeat (4) @(posedge clk_sys);
    axr(REG_PENDING);
    `CHK("unmasked pending", 32'h00000008, rd)
    run(mw(CTL_CONTINUE, SRC_OPCODE, 4'h0, 1'b0, 12'h000), 1'b0, 1'b0, 16'h003C);
    `CHK("vector", 12'h00B, micro_addr)
    `CHK("gate aborted", 1'b1, gate_n)
    run(mw(CTL_CONTINUE, 4'h0, 4'h0, 1'b0, 12'h000), 1'b0, 1'b0, 16'h003C);
    `CHK("no vector", 12'h00D, micro_addr)
    axw(REG_MASK, 32'h00000000);
    run(mw(CTL_CONTINUE, SRC_OPCODE, 4'h0, 1'b0, 12'h000), 1'b0, 1'b0, 16'h003C);
    `CHK("highest vector", 12'h00D, micro_addr)
    t_reset();
  endtask
  task automatic t_bus;
    for (int s = 0; s < NSEL; s++) begin
      run(mw(CTL_CONTINUE, 4'(s), 4'(15 - s), 1'b0, 12'h000), 1'b0, 1'b0, 16'h003C);
      `CHK("source select", ~(16'h0001 << s), bus_ctl.src_sel_n)
      `CHK("dest select", ~(16'h0001 << (15 - s)), bus_ctl.dst_sel_n)
      if (s >= 1 && s <= 4) begin
        `CHK("operand", {(s == 4) ? 8'hFF : 8'h00, 8'hA7}, bus_ctl.bus_out)
      end
    end
    run(mw(CTL_CONTINUE, 4'hE, 4'h9, 1'b1, 12'h000), 1'b0, 1'b1, 16'h0000);
    `CHK("const sources", 16'hFFFF, bus_ctl.src_sel_n)
    `CHK("const dest", 16'hFFFD, bus_ctl.dst_sel_n)
    `CHK("const bus", 16'h009E, bus_ctl.bus_out)
    `CHK("const drive", 1'b1, bus_ctl.bus_out_en)
    run(mw(CTL_CONTINUE, 4'hD, 4'h5, 1'b1, 12'h000), 1'b0, 1'b0, 16'h0000);
    `CHK("alu load", 16'h009E, alu_reg)
    run(mw(CTL_CONTINUE, 4'h0, DST_ALU, 1'b0, 12'h000), 1'b0, 1'b0, 16'h0000);
    `CHK("alu without strobe", 16'h009E, alu_reg)
  endtask
  task automatic t_mask_bus;
    run(mw(CTL_CONTINUE, 4'h0, DST_MASK, 1'b0, 12'h000), 1'b0, 1'b1, 16'h00C3);
    `CHK("mask strobe", 1'b1, mask_strobe)
    run(mw(CTL_CONTINUE, 4'h0, DST_MASK, 1'b0, 12'h000), 1'b0, 1'b0, 16'h0011);
    `CHK("mask strobe idle", 1'b0, mask_strobe)
    run(mw(CTL_CONTINUE, SRC_MASK, 4'h0, 1'b0, 12'h000), 1'b0, 1'b0, 16'h0000);
    `CHK("mask on bus", 16'h00C3, bus_ctl.bus_out)
    axr(REG_MASK);
    `CHK("mask loaded", 32'h000000C3, rd)
  endtask
  // ---------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------
  task automatic wrap_up;
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_sequence();
    t_dispatch();
    t_irq();
    t_bus();
    t_mask_bus();
    wrap_up();
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
endmodule
